// File: include/trc_consts.svh
// Purpose: Offsets, field positions, reset values and limits of the retry and rate controller.
// Assumes: 32-bit Avalon-MM register port, word addressed by byte offset.
// Notes:   Rate codes index the ordered table 6,9,12,18,24,36,48,54 Mbps.
`ifndef TRC_CONSTS_SVH
`define TRC_CONSTS_SVH
`define TRC_OFF_CTRL        8'h00
`define TRC_OFF_MAXRATE     8'h04
`define TRC_OFF_ATTEMPT     8'h08
`define TRC_OFF_REQUEUE     8'h0c
`define TRC_OFF_STATUS      8'h10
`define TRC_OFF_COUNTS      8'h14
`define TRC_CTRL_ADAPT_BIT  0
`define TRC_CTRL_MULTI_BIT  1
`define TRC_CTRL_SWRTY_BIT  2
`define TRC_CTRL_RESET      3'h7
`define TRC_RATE_MIN        3'h0
`define TRC_RATE_FULL_MAX   3'h7
`define TRC_RATE_RED_MAX    3'h4
`define TRC_ATTEMPT_RESET   4'h4
`define TRC_ATTEMPT_MAX     4'ha
`define TRC_REQUEUE_RESET   7'h03
`define TRC_REQUEUE_MIN     7'h01
`define TRC_REQUEUE_MAX     7'h64
`define TRC_HIST_MAX        2'h3
`define TRC_IDLE_LIMIT      16'hffff
`define TRC_RSSI_GOOD       8'h28
`define TRC_RSSI_POOR       8'h14
`endif

// File: include/trc_pkg.sv
// Purpose: Types shared by the retry and rate controller.
// Assumes: Nothing beyond the constants header.
// Notes:   Structs carry the frame request and the transmit order.
package trc_pkg;
  typedef logic [2:0] trc_rate_t;
  typedef struct packed {
    logic [3:0] dest;
    logic       unicast;
  } trc_frame_s;
  typedef struct packed {
    logic [3:0] dest;
    trc_rate_t  rate;
    logic       retry;
  } trc_tx_s;
  typedef enum logic [1:0] {TRC_OK, TRC_FAIL, TRC_REQUEUED, TRC_DROPPED} trc_outcome_e;
endpackage

// File: logic/trc_rate_table.sv
// Purpose: Per-destination rate decision state and choice of the next rate.
// Assumes: One result update per finished attempt.
// Notes:   Rates move between the lowest index and the cap only.
`include "trc_consts.svh"
module trc_rate_table #(
  parameter int DEST_COUNT = 16
) (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // Query.
  input  wire logic [3:0]        qDest,
  input  wire trc_pkg::trc_rate_t rateCap,
  input  wire logic              adaptOn,
  output trc_pkg::trc_rate_t     qRate,
  // Attempt outcome.
  input  wire logic              updValid,
  input  wire logic [3:0]        updDest,
  input  wire logic              updAcked,
  input  wire logic [7:0]        updRssi
);
  trc_pkg::trc_rate_t rate_reg [DEST_COUNT];
  trc_pkg::trc_rate_t rate_next [DEST_COUNT];
  logic [1:0]         hist_reg [DEST_COUNT];
  logic [1:0]         hist_next [DEST_COUNT];
  logic [15:0]        idle_reg [DEST_COUNT];
  logic [15:0]        idle_next [DEST_COUNT];

  // Each destination keeps its own rate, success run and idle time.
  for (genvar d = 0; d < DEST_COUNT; d++) begin : g_dest
    always_comb begin
      rate_next[d] = rate_reg[d];
      hist_next[d] = hist_reg[d];
      idle_next[d] = (idle_reg[d] == `TRC_IDLE_LIMIT) ? idle_reg[d] : idle_reg[d] + 16'h0001;
      if (updValid && updDest == 4'(d)) begin
        idle_next[d] = 16'h0000;
        if (!updAcked || updRssi < `TRC_RSSI_POOR) begin
          hist_next[d] = 2'h0;
          if (rate_reg[d] != `TRC_RATE_MIN) begin
            rate_next[d] = rate_reg[d] - 3'h1;
          end
        end else if (hist_reg[d] == `TRC_HIST_MAX && updRssi >= `TRC_RSSI_GOOD) begin
          hist_next[d] = 2'h0;
          if (rate_reg[d] < rateCap) begin
            rate_next[d] = rate_reg[d] + 3'h1;
          end
        end else if (hist_reg[d] != `TRC_HIST_MAX) begin
          hist_next[d] = hist_reg[d] + 2'h1;
        end
      end
    end
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        rate_reg[d] <= `TRC_RATE_MIN;
        hist_reg[d] <= 2'h0;
        idle_reg[d] <= 16'h0000;
      end else begin
        rate_reg[d] <= rate_next[d];
        hist_reg[d] <= hist_next[d];
        idle_reg[d] <= idle_next[d];
      end
    end
  end

  // Fixed rate when adaptation is off, otherwise clamp to the cap; a long idle drops one step.
  always_comb begin
    qRate = rate_reg[qDest];
    if (idle_reg[qDest] == `TRC_IDLE_LIMIT && qRate != `TRC_RATE_MIN) begin
      qRate = qRate - 3'h1;
    end
    if (!adaptOn || qRate > rateCap) begin
      qRate = rateCap;
    end
  end
endmodule // trc_rate_table

// File: logic/trc_reg_slave.sv
// Purpose: Avalon-MM register slave holding the controller settings.
// Assumes: One-cycle waitrequest on every access.
// Notes:   Out-of-range writes to the rate, attempt and requeue limits are ignored and keep the old value.
`include "trc_consts.svh"
module trc_reg_slave #(
  parameter bit FULL_RATE = 1'b1
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Avalon-MM slave.
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Settings and status.
  output logic [2:0]       ctrl,
  output logic [2:0]       maxRate,
  output logic [3:0]       attemptLimit,
  output logic [6:0]       requeueLimit,
  input  wire logic [31:0] statusWord,
  input  wire logic [31:0] countWord
);
  localparam logic [2:0] RateTop   = FULL_RATE ? `TRC_RATE_FULL_MAX : `TRC_RATE_RED_MAX;
  logic        ack_reg;
  logic        ack_next;
  logic        wait_reg;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [2:0]  ctrl_next;
  logic [2:0]  max_next;
  logic [3:0]  att_next;
  logic [6:0]  req_next;

  // Decode the access, range-check writes and assemble read data.
  always_comb begin
    ack_next  = (read || write) && !ack_reg;
    ctrl_next = ctrl;
    max_next  = maxRate;
    att_next  = attemptLimit;
    req_next  = requeueLimit;
    rd_next   = rd_reg;
    if (write && ack_reg) begin
      unique case (address)
        `TRC_OFF_CTRL: ctrl_next = writedata[2:0];
        `TRC_OFF_MAXRATE: if (writedata <= 32'(RateTop)) max_next = writedata[2:0];
        `TRC_OFF_ATTEMPT: if (writedata <= 32'(`TRC_ATTEMPT_MAX)) att_next = writedata[3:0];
        `TRC_OFF_REQUEUE: if (writedata >= 32'(`TRC_REQUEUE_MIN) && writedata <= 32'(`TRC_REQUEUE_MAX)) begin
          req_next = writedata[6:0];
        end
        default: ;
      endcase
    end
    if (read && !ack_reg) begin
      unique case (address)
        `TRC_OFF_CTRL:    rd_next = {29'h0, ctrl};
        `TRC_OFF_MAXRATE: rd_next = {29'h0, maxRate};
        `TRC_OFF_ATTEMPT: rd_next = {28'h0, attemptLimit};
        `TRC_OFF_REQUEUE: rd_next = {25'h0, requeueLimit};
        `TRC_OFF_STATUS:  rd_next = statusWord;
        `TRC_OFF_COUNTS:  rd_next = countWord;
        default:          rd_next = 32'h0;
      endcase
    end
  end

  // Register settings; the slave answers on the second cycle of each access.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_reg      <= 1'b0;
      wait_reg     <= 1'b1;
      rd_reg       <= 32'h0;
      ctrl         <= `TRC_CTRL_RESET;
      maxRate      <= RateTop;
      attemptLimit <= `TRC_ATTEMPT_RESET;
      requeueLimit <= `TRC_REQUEUE_RESET;
    end else begin
      ack_reg      <= ack_next;
      wait_reg     <= !ack_next;
      rd_reg       <= rd_next;
      ctrl         <= ctrl_next;
      maxRate      <= max_next;
      attemptLimit <= att_next;
      requeueLimit <= req_next;
    end
  end

  // Waitrequest comes from a flop: high while idle, low for the one answering cycle.
  assign waitrequest = wait_reg;
  assign readdata    = rd_reg;
endmodule // trc_reg_slave

// File: logic/trc_retry_ctrl.sv
// Purpose: Transmit retry and rate controller for one frame at a time.
// Assumes: Queue offers a frame with valid; transmitter answers each attempt with one result pulse.
// Notes:   Requeue pulses frameRequeue and resends the held frame at once from a clear attempt count.
//
// The register addresses and the Avalon-MM register port were decided locally.
`include "trc_consts.svh"
module trc_retry_ctrl #(
  parameter bit FULL_RATE  = 1'b1,
  parameter int DEST_COUNT = 16
) (
  // Clock and reset.
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // Avalon-MM register port.
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  // Transmit queue head.
  input  wire logic               frameValid,
  input  wire trc_pkg::trc_frame_s frameIn,
  output logic                    frameTake,
  output logic                    frameRequeue,
  output logic                    frameDrop,
  output logic                    frameDone,
  // Radio transmitter.
  output logic                    txStart,
  output trc_pkg::trc_tx_s        txOrder,
  input  wire logic               txResult,
  input  wire logic               txAcked,
  input  wire logic [7:0]         txRssi
);
  typedef enum {IDLE, SEND, WAIT} trc_state_e;
  trc_state_e          state_reg, state_next;
  trc_pkg::trc_frame_s frame_reg, frame_next;
  trc_pkg::trc_rate_t  rate_reg, rate_next;
  logic [3:0]          hw_reg, hw_next;
  logic [6:0]          sw_reg, sw_next;
  logic                start_reg, start_next;
  trc_pkg::trc_tx_s    order_reg, order_next;
  logic                take_reg, take_next;
  logic                req_reg, req_next;
  logic                drop_reg, drop_next;
  logic                done_reg, done_next;
  logic [15:0]         dropCnt_reg, dropCnt_next;
  logic [15:0]         reqCnt_reg, reqCnt_next;
  logic [2:0]          ctrl;
  logic [2:0]          maxRate;
  logic [3:0]          attemptLimit;
  logic [6:0]          requeueLimit;
  trc_pkg::trc_rate_t  qRate;
  logic                multiOn;
  logic                swRetryOn;
  logic                adaptOn;

  assign adaptOn   = ctrl[`TRC_CTRL_ADAPT_BIT];
  assign multiOn   = ctrl[`TRC_CTRL_MULTI_BIT];
  assign swRetryOn = ctrl[`TRC_CTRL_SWRTY_BIT];

  // Assertions below take this clock and reset unless they name their own.
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Settings registers and status readback.
  trc_reg_slave #(.FULL_RATE(FULL_RATE)) u_regs (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .address      (address),
    .read         (read),
    .write        (write),
    .writedata    (writedata),
    .readdata     (readdata),
    .waitrequest  (waitrequest),
    .ctrl         (ctrl),
    .maxRate      (maxRate),
    .attemptLimit (attemptLimit),
    .requeueLimit (requeueLimit),
    .statusWord   ({16'h0, 4'h0, frame_reg.dest, sw_reg[3:0], hw_reg}),
    .countWord    ({reqCnt_reg, dropCnt_reg})
  );

  // Per-destination rate choice, updated from each attempt outcome.
  trc_rate_table #(.DEST_COUNT(DEST_COUNT)) u_rates (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .qDest    (state_reg == IDLE ? frameIn.dest : frame_reg.dest),
    .rateCap  (maxRate),
    .adaptOn  (adaptOn && multiOn),
    .qRate    (qRate),
    .updValid (txResult && state_reg == WAIT),
    .updDest  (frame_reg.dest),
    .updAcked (txAcked),
    .updRssi  (txRssi)
  );

  // Frame sequencing: take, send, retry at same rate, requeue or drop.
  always_comb begin
    state_next   = state_reg;
    frame_next   = frame_reg;
    rate_next    = rate_reg;
    hw_next      = hw_reg;
    sw_next      = sw_reg;
    start_next   = 1'b0;
    order_next   = order_reg;
    take_next    = 1'b0;
    req_next     = 1'b0;
    drop_next    = 1'b0;
    done_next    = 1'b0;
    dropCnt_next = dropCnt_reg;
    reqCnt_next  = reqCnt_reg;
    unique case (state_reg)
      IDLE: if (frameValid) begin
        frame_next = frameIn;
        rate_next  = qRate;
        hw_next    = 4'h0;
        sw_next    = 7'h00;
        take_next  = 1'b1;
        state_next = SEND;
      end
      SEND: begin
        start_next = 1'b1;
        order_next = '{dest: frame_reg.dest, rate: rate_reg, retry: hw_reg != 4'h0};
        state_next = WAIT;
      end
      WAIT: if (txResult) begin
        if (txAcked) begin
          done_next  = 1'b1;
          hw_next    = 4'h0;
          sw_next    = 7'h00;
          state_next = IDLE;
        end else if (hw_reg < attemptLimit) begin
          hw_next    = hw_reg + 4'h1;
          state_next = SEND;
        end else if (multiOn && swRetryOn && sw_reg < requeueLimit) begin
          req_next    = 1'b1;
          reqCnt_next = reqCnt_reg + 16'h0001;
          sw_next     = sw_reg + 7'h01;
          hw_next     = 4'h0;
          rate_next   = qRate;
          state_next  = SEND;
        end else begin
          drop_next    = 1'b1;
          dropCnt_next = dropCnt_reg + 16'h0001;
          hw_next      = 4'h0;
          sw_next      = 7'h00;
          state_next   = IDLE;
        end
      end
    endcase
  end

  // Register the sequencing state and the outputs.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg   <= IDLE;
      frame_reg   <= '0;
      rate_reg    <= `TRC_RATE_MIN;
      hw_reg      <= 4'h0;
      sw_reg      <= 7'h00;
      start_reg   <= 1'b0;
      order_reg   <= '0;
      take_reg    <= 1'b0;
      req_reg     <= 1'b0;
      drop_reg    <= 1'b0;
      done_reg    <= 1'b0;
      dropCnt_reg <= 16'h0;
      reqCnt_reg  <= 16'h0;
    end else begin
      state_reg   <= state_next;
      frame_reg   <= frame_next;
      rate_reg    <= rate_next;
      hw_reg      <= hw_next;
      sw_reg      <= sw_next;
      start_reg   <= start_next;
      order_reg   <= order_next;
      take_reg    <= take_next;
      req_reg     <= req_next;
      drop_reg    <= drop_next;
      done_reg    <= done_next;
      dropCnt_reg <= dropCnt_next;
      reqCnt_reg  <= reqCnt_next;
    end
  end

  assign txStart      = start_reg;
  assign txOrder      = order_reg;
  assign frameTake    = take_reg;
  assign frameRequeue = req_reg;
  assign frameDrop    = drop_reg;
  assign frameDone    = done_reg;

  // Attempt count never passes the limit within a sequence.
  a_attempt_bound: assert property (@(posedge ref_clk) disable iff (reset)
    hw_reg <= attemptLimit || $changed(attemptLimit)) else $error("attempt count above limit");
  // Retransmissions keep the rate of the sequence.
  a_retry_same_rate: assert property (@(posedge ref_clk) disable iff (reset)
    txStart && txOrder.retry |-> txOrder.rate == $past(rate_reg, 2)) else $error("retry rate changed");
  // Rate never exceeds the configured maximum.
  a_rate_capped: assert property (@(posedge ref_clk) disable iff (reset)
    txStart && !$changed(maxRate) |-> txOrder.rate <= maxRate) else $error("rate above maximum");
  // Fixed rate when adaptation is off.
  a_fixed_rate: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == IDLE && frameValid && !adaptOn |=> rate_reg == $past(maxRate)) else $error("fixed rate not used");
  // Drop without software retry once attempts are exhausted.
  a_drop_no_swretry: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == WAIT && txResult && !txAcked && hw_reg >= attemptLimit && !(multiOn && swRetryOn)
    |=> frameDrop && !frameRequeue) else $error("frame not dropped");
  // Requeue limit respected.
  a_requeue_bound: assert property (@(posedge ref_clk) disable iff (reset)
    frameRequeue |-> sw_reg <= requeueLimit || $changed(requeueLimit)) else $error("too many requeues");
  // Counters clear after acknowledge or drop.
  a_counters_clear: assert property (@(posedge ref_clk) disable iff (reset)
    frameDone || frameDrop |-> hw_reg == 4'h0 && sw_reg == 7'h00) else $error("counters not cleared");
  // A take pulse is followed by a first attempt one cycle later.
  a_first_attempt: assert property (@(posedge ref_clk) disable iff (reset)
    frameTake |=> txStart && !txOrder.retry && txOrder.rate == $past(rate_reg)) else $error("first attempt wrong");

  // Outcomes of one attempt as seen in the wait state.
  sequence s_attempt_failed;
    state_reg == WAIT && txResult && !txAcked && hw_reg < attemptLimit;
  endsequence
  sequence s_attempts_spent;
    state_reg == WAIT && txResult && !txAcked && hw_reg >= attemptLimit;
  endsequence
  // A new attempt sequence opens with a start that is not a retry.
  sequence s_fresh_start;
    txStart && !txOrder.retry;
  endsequence

  // A failure inside the limit is sent again as a retry.
  a_retry_follows: assert property (
    s_attempt_failed |=> ##1 txStart && txOrder.retry
  ) else $error("retry missing");

  // A spent sequence with requeues left pulses frameRequeue and restarts fresh.
  a_requeue_fresh: assert property (
    s_attempts_spent ##0 (multiOn && swRetryOn && sw_reg < requeueLimit) |=> frameRequeue ##1 s_fresh_start
  ) else $error("requeue not followed by fresh start");

  // A spent sequence with no requeues left drops the frame.
  a_drop_spent: assert property (
    s_attempts_spent ##0 (multiOn && swRetryOn && sw_reg >= requeueLimit) |=> frameDrop && !frameRequeue
  ) else $error("frame not dropped at requeue limit");

  // An acknowledge finishes the frame and clears the attempt count.
  a_ack_done: assert property (
    state_reg == WAIT && txResult && txAcked |=> frameDone && state_reg == IDLE && hw_reg == 4'h0
  ) else $error("acknowledge not finished");

  // A newly taken frame starts with clear counters.
  a_take_clean: assert property (
    frameTake |-> state_reg == SEND && hw_reg == 4'h0 && sw_reg == 7'h00
  ) else $error("counters not clear at take");

  // At most one queue event per cycle.
  a_one_outcome: assert property (
    $onehot0({frameTake, frameDone, frameDrop, frameRequeue})
  ) else $error("queue events overlap");

  // The order word only changes together with a start.
  a_order_holds: assert property (
    !txStart |-> $stable(txOrder)
  ) else $error("order changed without start");

  // A zero attempt limit never retransmits.
  a_zero_limit: assert property (
    txStart && txOrder.retry |-> attemptLimit != 4'h0
  ) else $error("retry with zero limit");

  // Stored limits stay inside their legal ranges.
  a_limits_legal: assert property (
    attemptLimit <= `TRC_ATTEMPT_MAX && requeueLimit >= `TRC_REQUEUE_MIN && requeueLimit <= `TRC_REQUEUE_MAX
  ) else $error("limit out of range");

  // The reduced variant never holds a cap above its top rate.
  a_reduced_cap: assert property (
    FULL_RATE || maxRate <= `TRC_RATE_RED_MAX
  ) else $error("reduced cap too high");

  // With adaptation off a requeued frame keeps the fixed rate.
  a_fixed_requeue: assert property (
    frameRequeue && !adaptOn |-> rate_reg == $past(maxRate)
  ) else $error("fixed rate lost on requeue");
endmodule // trc_retry_ctrl

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the transmit retry and rate controller.
// Assumes: The radio stand-in answers every attempt; settings sit on Avalon-MM.
// Notes:   The driver notes every expected event, the monitor checks them in order.
`include "trc_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] kind;
    logic [3:0] dest;
    logic [2:0] rate;
    logic       retry;
    logic       sameRate;
    logic       anyRate;
    logic       anyRetry;
  } trc_note_s;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic busRead = 1'b0;
  logic busWrite = 1'b0;
  logic sel = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] rd1, rd2, busData;
  logic wr1, wr2, busWait;
  logic frameValid = 1'b0;
  trc_pkg::trc_frame_s frameIn = '0;
  logic frameTake, frameRequeue, frameDrop, frameDone, txStart, txResult, txAcked;
  trc_pkg::trc_tx_s txOrder;
  logic [7:0] txRssi;
  logic [3:0] failPlan = 4'h0;
  logic slow = 1'b0;
  logic [7:0] rssiLevel = 8'h30;
  logic [2:0] ctrlV, maxR, lastRate;
  logic [3:0] attLim;
  logic [6:0] reqLim;
  trc_note_s notes[$];
  logic [63:0] regNotes[$];
  int fail_count = 0;
  int checks_done = 0;
  int k;
  assign busWait = sel ? wr2 : wr1;
  assign busData = sel ? rd2 : rd1;
  // Clock at 50 MHz.
  always #10 ref_clk = ~ref_clk;
  trc_retry_ctrl #(.FULL_RATE(1'b1)) dut (.ref_clk(ref_clk), .reset(reset), .address(address),
    .read(busRead & ~sel), .write(busWrite & ~sel), .writedata(writedata), .readdata(rd1),
    .waitrequest(wr1), .frameValid(frameValid), .frameIn(frameIn), .frameTake(frameTake),
    .frameRequeue(frameRequeue), .frameDrop(frameDrop), .frameDone(frameDone), .txStart(txStart),
    .txOrder(txOrder), .txResult(txResult), .txAcked(txAcked), .txRssi(txRssi));
  trc_retry_ctrl #(.FULL_RATE(1'b0)) dutReduced (.ref_clk(ref_clk), .reset(reset), .address(address),
    .read(busRead & sel), .write(busWrite & sel), .writedata(writedata), .readdata(rd2),
    .waitrequest(wr2), .frameValid(1'b0), .frameIn(frameIn), .frameTake(), .frameRequeue(), .frameDrop(),
    .frameDone(), .txStart(), .txOrder(), .txResult(txResult), .txAcked(txAcked), .txRssi(txRssi));
  trc_radio_model radio (.ref_clk(ref_clk), .reset(reset), .txStart(txStart), .txResult(txResult),
    .txAcked(txAcked), .txRssi(txRssi), .failPlan(failPlan), .slow(slow), .rssiLevel(rssiLevel));
  task automatic report(input string msg);
    fail_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check_event(input logic [2:0] kind, input trc_pkg::trc_tx_s ord);
    trc_note_s n;
    checks_done++;
    if (notes.size() == 0) begin
      report("event with nothing expected");
      return;
    end
    n = notes.pop_front();
    if (n.kind !== kind) report("event out of order");
    else if (kind == 3'h2) begin
      if (ord.dest !== n.dest || (ord.rate <= maxR) !== 1'b1) report("order destination or rate cap wrong");
      if (!n.anyRetry && ord.retry !== n.retry) report("order retry flag wrong");
      if (n.sameRate ? ord.rate !== lastRate : (!n.anyRate && ord.rate !== n.rate)) report("order rate wrong");
      lastRate = ord.rate;
    end
  endtask
  task automatic check_reg(input logic [31:0] q);
    logic [63:0] e;
    checks_done++;
    e = regNotes.pop_front();
    if ((q & e[63:32]) !== e[31:0]) report("register value differs");
  endtask
  // Monitor: every result the controller shows is matched against the oldest note.
  always @(posedge ref_clk) begin
    if (!reset) begin
      if (busRead && busWait === 1'b0) check_reg(busData);
      if (frameTake === 1'b1) check_event(3'h1, txOrder);
      if (txStart === 1'b1) check_event(3'h2, txOrder);
      if (frameDone === 1'b1) check_event(3'h3, txOrder);
      if (frameRequeue === 1'b1) check_event(3'h4, txOrder);
      if (frameDrop === 1'b1) check_event(3'h5, txOrder);
    end
  end
  task automatic reg_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int i;
    address <= a;
    busWrite <= wr;
    busRead <= !wr;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (busWait === 1'b0) break;
    end
    if (i == 20) begin
      report("bus answer timed out");
      wrap_up();
    end
    busRead <= 1'b0;
    busWrite <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    regNotes.push_back({mask, exp});
    reg_xfer(a, 1'b0, 32'h0);
  endtask
  task automatic cfg(input logic [2:0] c, input logic [2:0] m, input logic [3:0] a, input logic [6:0] r);
    ctrlV = c;
    maxR = m;
    attLim = a;
    reqLim = r;
    reg_xfer(`TRC_OFF_CTRL, 1'b1, {29'h0, c});
    reg_xfer(`TRC_OFF_MAXRATE, 1'b1, {29'h0, m});
    reg_xfer(`TRC_OFF_ATTEMPT, 1'b1, {28'h0, a});
    reg_xfer(`TRC_OFF_REQUEUE, 1'b1, {25'h0, r});
  endtask
  // Notes the whole expected life of one frame, then offers it and waits for the last event.
  task automatic send_frame(input logic [3:0] dest, input logic [3:0] fails, input logic isSlow);
    trc_note_s n;
    int s, j, att, w;
    logic fin, fixed;
    fixed = !ctrlV[0] || !ctrlV[1];
    failPlan <= fails;
    slow <= isSlow;
    rssiLevel <= 8'($urandom);
    n = '0;
    n.kind = 3'h1;
    notes.push_back(n);
    att = 0;
    fin = 1'b0;
    for (s = 0; s <= reqLim && !fin; s++) begin
      for (j = 0; j <= attLim && !fin; j++) begin
        n = '0;
        n.kind = 3'h2;
        n.dest = dest;
        n.rate = fixed ? maxR : 3'h0;
        n.retry = j != 0;
        n.sameRate = j != 0 && !fixed;
        n.anyRate = !fixed;
        n.anyRetry = j == 0 && s != 0;
        notes.push_back(n);
        fin = att == fails;
        att++;
      end
      n = '0;
      n.kind = fin ? 3'h3 : (!ctrlV[1] || !ctrlV[2] || s == reqLim) ? 3'h5 : 3'h4;
      notes.push_back(n);
      fin = fin || n.kind == 3'h5;
    end
    frameIn <= '{dest: dest, unicast: 1'b1};
    frameValid <= 1'b1;
    for (w = 0; w < 4000 && notes.size() != 0; w++) begin
      @(posedge ref_clk);
      if (frameTake === 1'b1) frameValid <= 1'b0;
    end
    if (w == 4000) begin
      report("frame never finished");
      wrap_up();
    end
    // Park the plan so the stand-in clears its failure count before the next frame.
    failPlan <= 4'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  // Main sequence: reset, settings, then frames through every retry path.
  initial begin
    void'($urandom(49149));
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    reg_rd(`TRC_OFF_CTRL, 32'hffffffff, 32'h7);
    reg_rd(`TRC_OFF_MAXRATE, 32'hffffffff, 32'h7);
    reg_rd(`TRC_OFF_ATTEMPT, 32'hffffffff, 32'h4);
    reg_rd(`TRC_OFF_REQUEUE, 32'hffffffff, 32'h3);
    reg_rd(8'h20, 32'hffffffff, 32'h0);
    sel <= 1'b1;
    reg_rd(`TRC_OFF_MAXRATE, 32'hffffffff, 32'h4);
    reg_xfer(`TRC_OFF_MAXRATE, 1'b1, 32'h5);
    reg_rd(`TRC_OFF_MAXRATE, 32'hffffffff, 32'h4);
    sel <= 1'b0;
    reg_xfer(`TRC_OFF_ATTEMPT, 1'b1, 32'hb);
    reg_rd(`TRC_OFF_ATTEMPT, 32'hffffffff, 32'h4);
    reg_xfer(`TRC_OFF_ATTEMPT, 1'b1, 32'ha);
    reg_rd(`TRC_OFF_ATTEMPT, 32'hffffffff, 32'ha);
    reg_xfer(`TRC_OFF_REQUEUE, 1'b1, 32'h0);
    reg_xfer(`TRC_OFF_REQUEUE, 1'b1, 32'h65);
    reg_rd(`TRC_OFF_REQUEUE, 32'hffffffff, 32'h3);
    reg_xfer(`TRC_OFF_REQUEUE, 1'b1, 32'h64);
    reg_rd(`TRC_OFF_REQUEUE, 32'hffffffff, 32'h64);
    cfg(3'h6, 3'h5, 4'h2, 7'h1);
    send_frame(4'h3, 4'hf, 1'b0);
    cfg(3'h3, 3'h7, 4'h0, 7'h3);
    send_frame(4'h5, 4'hf, 1'b1);
    cfg(3'h5, 3'h6, 4'h1, 7'h3);
    send_frame(4'h6, 4'hf, 1'b0);
    cfg(3'h7, 3'h7, 4'h1, 7'h2);
    send_frame(4'h9, 4'hf, 1'b0);
    reg_rd(`TRC_OFF_STATUS, 32'h000000ff, 32'h0);
    reg_rd(`TRC_OFF_COUNTS, 32'hffffffff, 32'h00030004);
    cfg(3'h7, 3'h7, 4'h4, 7'h3);
    send_frame(4'h1, 4'h1, 1'b1);
    for (k = 0; k < 8; k++) begin
      send_frame(4'($urandom), 4'($urandom_range(4, 0)), 1'($urandom));
    end
    cfg(3'h7, 3'h0, 4'h4, 7'h3);
    send_frame(4'h2, 4'h2, 1'b0);
    reg_rd(`TRC_OFF_STATUS, 32'h000000ff, 32'h0);
    wrap_up();
  end
endmodule // testbench

// File: testbench/trc_radio_model.sv
// Purpose: Radio transmitter stand-in that answers every attempt with one result pulse.
// Assumes: One attempt is in the air at a time.
// Notes:   The first failPlan attempts after a plan change fail; 4'hf never acknowledges.
module trc_radio_model (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Attempt request and answer.
  input  wire logic       txStart,
  output logic            txResult,
  output logic            txAcked,
  output logic [7:0]      txRssi,
  // Behaviour control.
  input  wire logic [3:0] failPlan,
  input  wire logic       slow,
  input  wire logic [7:0] rssiLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] failCnt;
  logic [3:0] lastPlan;
  logic [3:0] waitCnt;
  logic       busy;
  // Times one attempt and answers at its end; outside answers the qualifiers toggle so nothing stale looks valid.
  always @(posedge ref_clk) begin
    txResult <= 1'b0;
    txAcked  <= ~txAcked;
    txRssi   <= ~txRssi;
    lastPlan <= failPlan;
    if (reset) begin
      busy    <= 1'b0;
      failCnt <= 4'h0;
      txAcked <= 1'b0;
      txRssi  <= 8'h5a;
    end else begin
      if (lastPlan != failPlan) begin
        failCnt <= 4'h0;
      end
      if (txStart) begin
        busy    <= 1'b1;
        waitCnt <= slow ? 4'h9 : 4'h1;
      end else if (busy && waitCnt != 4'h0) begin
        waitCnt <= waitCnt - 4'h1;
      end else if (busy) begin
        busy     <= 1'b0;
        txResult <= 1'b1;
        txAcked  <= failCnt >= failPlan && failPlan != 4'hf;
        txRssi   <= rssiLevel;
        if (failCnt < failPlan) begin
          failCnt <= failCnt + 4'h1;
        end
      end
    end
  end
endmodule // trc_radio_model
